// [pkg/eit_pkg.sv]
// Constants for the eight-bit interval timer
package eit_pkg;
   localparam logic [15:0] EIT_ADDR_CONTROL = 16'hFFCC;
   localparam logic [15:0] EIT_ADDR_COMPARE = 16'hFFCD;
   localparam logic [15:0] EIT_ADDR_COUNT   = 16'hFFCE;
   localparam int          EIT_RUN_BIT      = 7;
   localparam int          EIT_SEL_HI_BIT   = 2;
   localparam int          EIT_SEL_LO_BIT   = 1;
   localparam logic [7:0]  EIT_CONTROL_RST  = 8'h00;
   localparam logic [7:0]  EIT_CONTROL_MASK = 8'h86;
   localparam logic [7:0]  EIT_COUNT_RST    = 8'h00;
   localparam logic [7:0]  EIT_COMPARE_RST  = 8'h00;
   localparam int          EIT_DIV_W        = 16;
   localparam int          EIT_TAP_SEL0     = 5;
   localparam int          EIT_TAP_SEL1     = 7;
   localparam int          EIT_TAP_SEL2     = 9;
   localparam int          EIT_TAP_SEL3     = 15;
endpackage

// [src/eit_prescaler.sv]
// Free-running divider producing the selected count clock level
`timescale 1ns/1ns
module eit_prescaler
   import eit_pkg::*;
#(
   parameter int DIV_W = EIT_DIV_W
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] sel,
   output logic            count_clk
);
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic             cc_q;
   logic             cc_d;

   always_comb begin
      div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      case (sel)
         2'h0: cc_d = div_q[EIT_TAP_SEL0];
         2'h1: cc_d = div_q[EIT_TAP_SEL1];
         2'h2: cc_d = div_q[EIT_TAP_SEL2];
         default: cc_d = div_q[EIT_TAP_SEL3];
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
         cc_q  <= 1'b0;
      end else begin
         div_q <= div_d;
         cc_q  <= cc_d;
      end
   end

   assign count_clk = cc_q;
endmodule // eit_prescaler

// [src/eit_timer.sv]
// Eight-bit interval timer with control, compare and count registers
`timescale 1ns/1ns
module eit_timer
   import eit_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] addr,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  wdata,
   output logic [7:0]       rdata,
   output logic             match_irq
);
   typedef enum logic [1:0] {
      EIT_IDLE = 2'b01,
      EIT_RUN  = 2'b10
   } eit_state_e;

   // Counter state
   eit_state_e state_q;
   eit_state_e state_d;
   logic [7:0] count_value_q;
   logic [7:0] count_value_d;
   logic       irq_q;
   logic       irq_d;

   // Software visible registers
   logic [7:0] timer_control_q;
   logic [7:0] timer_control_d;
   logic [7:0] compare_value_q;
   logic [7:0] compare_value_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // Count clock and its edge detector
   logic       count_clk;
   logic       cc_prev_q;
   logic       cc_prev_d;
   logic       cc_rise;

   // Control fields and bus decode
   logic       run_enable;
   logic [1:0] clock_sel;
   logic       count_match;
   logic       ctl_wr;
   logic       cmp_wr;
   logic       ctl_rd;
   logic       cnt_rd;

   // Address decode shared by the write and read paths
   function automatic logic hit(
      input logic [15:0] a,
      input logic [15:0] ref_a
   );
      hit = (a == ref_a);
   endfunction

   // Free-running divider, not restarted at enable
   eit_prescaler #(
      .DIV_W(EIT_DIV_W)
   ) u_prescaler (
      .clk      (clk),
      .rst_n    (rst_n),
      .sel      (clock_sel),
      .count_clk(count_clk)
   );

   assign run_enable = timer_control_q[EIT_RUN_BIT];
   assign clock_sel  = {timer_control_q[EIT_SEL_HI_BIT], timer_control_q[EIT_SEL_LO_BIT]};
   assign cc_rise    = count_clk & ~cc_prev_q;

   // Bus strobes decoded once for the register groups
   // Writes to the count address are ignored
   assign ctl_wr     = wr_en & hit(addr, EIT_ADDR_CONTROL);
   assign cmp_wr     = wr_en & hit(addr, EIT_ADDR_COMPARE);
   assign ctl_rd     = rd_en & hit(addr, EIT_ADDR_CONTROL);
   assign cnt_rd     = rd_en & hit(addr, EIT_ADDR_COUNT);

   // Match seen at all times, acted on at the next count clock edge
   assign count_match = (count_value_q == compare_value_q);

   // Control register, reserved bits held at zero
   always_comb begin
      timer_control_d = timer_control_q;
      if (ctl_wr) begin
         // Bits 0 and 3 to 6 cannot be set by a careless write
         timer_control_d = wdata & EIT_CONTROL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_q <= EIT_CONTROL_RST;
      end else begin
         timer_control_q <= timer_control_d;
      end
   end

   // Compare register
   always_comb begin
      compare_value_d = compare_value_q;
      if (cmp_wr) begin
         // Accepted while running; a match may then fire at the next count clock edge
         compare_value_d = wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_value_q <= EIT_COMPARE_RST;
      end else begin
         compare_value_q <= compare_value_d;
      end
   end

   // Read data, zero unless a readable register is addressed
   // Compare is write-only and reads as zero
   always_comb begin
      rdata_d = 8'h00;
      if (ctl_rd) begin
         rdata_d = timer_control_q;
      end else if (cnt_rd) begin
         rdata_d = count_value_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Counter state machine
   always_comb begin
      state_d       = state_q;
      count_value_d = count_value_q;
      irq_d         = 1'b0;
      case (state_q)
         EIT_IDLE: begin
            // Stopped: count held at zero until enabled
            count_value_d = EIT_COUNT_RST;
            if (run_enable) begin
               state_d = EIT_RUN;
            end
         end
         EIT_RUN: begin
            if (!run_enable) begin
               // Stopping drops any pending edge
               state_d       = EIT_IDLE;
               count_value_d = EIT_COUNT_RST;
            end else if (cc_rise) begin
               // Zero compare matches on every rising edge
               if (count_match) begin
                  count_value_d = EIT_COUNT_RST;
                  irq_d         = 1'b1;
               end else begin
                  count_value_d = count_value_q + 8'h01;
               end
            end
         end
         default: begin
            // Illegal state code returns to idle
            state_d       = EIT_IDLE;
            count_value_d = EIT_COUNT_RST;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= EIT_IDLE;
         count_value_q <= EIT_COUNT_RST;
         irq_q         <= 1'b0;
      end else begin
         state_q       <= state_d;
         count_value_q <= count_value_d;
         irq_q         <= irq_d;
      end
   end

   // Count clock edge detector
   always_comb begin
      // Level tracked while stopped, forced low at enable so a high clock counts at once
      cc_prev_d = count_clk;
      if (state_q == EIT_IDLE && run_enable) begin
         cc_prev_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cc_prev_q <= 1'b0;
      end else begin
         cc_prev_q <= cc_prev_d;
      end
   end

   // Outputs straight from flops
   assign rdata     = rdata_q;
   assign match_irq = irq_q;
endmodule // eit_timer

// [verif/eit_timer_monitor.sv]
// Port checker for the interval timer
`timescale 1ns/1ns
module eit_timer_monitor
   import eit_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] addr,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        match_irq
);
   logic [7:0]  ctl_q, ctl_d, cmp_q, cmp_d;
   logic [31:0] gap_q, gap_d, per;
   logic        ok_q, ok_d;
   always_comb begin
      ctl_d = (wr_en && addr == EIT_ADDR_CONTROL) ? wdata & EIT_CONTROL_MASK : ctl_q;
      cmp_d = (wr_en && addr == EIT_ADDR_COMPARE) ? wdata : cmp_q;
      gap_d = match_irq ? 32'h1 : gap_q + 32'h1;
      ok_d  = !wr_en && (match_irq || ok_q);
      per   = ({24'h0, cmp_q} + 32'h1) << (ctl_q[2:1] == 2'h3 ? 16 : 6 + 2 * ctl_q[2:1]);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ctl_q, cmp_q, gap_q, ok_q} <= '0;
      end else begin
         {ctl_q, cmp_q, gap_q, ok_q} <= {ctl_d, cmp_d, gap_d, ok_d};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_irq_one_cycle: assert property (match_irq |=> !match_irq) else $error("irq wide");
   a_rdata_idle_zero: assert property (!rd_en |=> rdata == 8'h00)
      else $error("rdata not idle");
   a_compare_write_only: assert property (rd_en && addr == EIT_ADDR_COMPARE |=> rdata == 8'h00)
      else $error("compare readable");
   a_ctrl_masked_read: assert property (rd_en && addr == EIT_ADDR_CONTROL && !wr_en
      |=> rdata == $past(ctl_q)) else $error("control readback");
   a_stop_no_irq: assert property ((!ctl_q[7]) [*3] |-> !match_irq) else $error("irq stopped");
   a_stop_count_zero: assert property (rd_en && addr == EIT_ADDR_COUNT && !ctl_q[7]
      && $past(!ctl_q[7]) |=> rdata == 8'h00) else $error("count not cleared");
   a_irq_period_exact: assert property (match_irq && ok_q |-> gap_q == per)
      else $error("irq period");
   a_count_in_range: assert property (rd_en && addr == EIT_ADDR_COUNT && ok_q
      |=> rdata <= $past(cmp_q)) else $error("count above compare");
   c_period: cover property (match_irq && ok_q);
   c_stop_read: cover property (rd_en && addr == EIT_ADDR_COUNT && !ctl_q[7]);
   c_enable: cover property (wr_en && addr == EIT_ADDR_CONTROL && wdata[7]);
endmodule // eit_timer_monitor
bind eit_timer eit_timer_monitor eit_timer_monitor_i (.clk, .rst_n, .addr, .wr_en, .rd_en,
   .wdata, .rdata, .match_irq);

// [verif/tb_top.sv]
// Self-checking bench for the interval timer
`timescale 1ns/1ns
module tb_top import eit_pkg::*; ;
   typedef struct {logic [1:0] s; logic [7:0] c; int p;} eit_row_s;
   logic        clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, match_irq;
   logic [15:0] addr = '0;
   logic [7:0]  wdata = '0, rdata;
   int          fails = 0, num_checks = 0, cyc = 0, n;
   eit_row_s    rows [4] = '{'{2'h0, 8'h00, 64}, '{2'h1, 8'h02, 768}, '{2'h2, 8'h01, 2048},
                             '{2'h0, 8'hFF, 16384}};
   eit_timer eit_timer_i (.clk, .rst_n, .addr, .wr_en, .rd_en, .wdata, .rdata, .match_irq);
   initial forever #50 clk = ~clk;
   always @(posedge clk) if (++cyc == 60000) begin
      fails++;
      print_verdict();
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(negedge clk);
      {addr, wdata, wr_en} = {a, d, 1'b1};
      @(negedge clk);
      wr_en = 0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(negedge clk);
      {addr, rd_en} = {a, 1'b1};
      @(negedge clk);
      rd_en = 0;
      chk("rdata", {24'h0, e}, {24'h0, rdata});
   endtask
   // Waits for the request pulse, n counts cycles
   task automatic wirq();
      n = 0;
      while (match_irq !== 1'b1 && n < 70000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1;
      rd(EIT_ADDR_CONTROL, 8'h00);
      rd(EIT_ADDR_COUNT, 8'h00);
      rd(EIT_ADDR_COMPARE, 8'h00);
      wr(EIT_ADDR_CONTROL, 8'hBE);
      rd(EIT_ADDR_CONTROL, 8'h86);
      foreach (rows[i]) begin
         wr(EIT_ADDR_CONTROL, {5'h0, rows[i].s, 1'b0});
         wr(EIT_ADDR_COMPARE, rows[i].c);
         wr(EIT_ADDR_CONTROL, {5'h10, rows[i].s, 1'b0});
         wirq();
         @(negedge clk);
         wirq();
         chk("period", rows[i].p, n + 1);
      end
      repeat (100) @(negedge clk);
      rd(EIT_ADDR_COUNT, 8'h01);
      wr(EIT_ADDR_CONTROL, 8'h00);
      rd(EIT_ADDR_COUNT, 8'h00);
      rd(16'h0000, 8'h00);
      // Reset in mid-run
      wr(EIT_ADDR_CONTROL, 8'h80);
      repeat (200) @(negedge clk);
      rst_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1;
      chk("match_irq", 32'h0, {31'h0, match_irq});
      rd(EIT_ADDR_CONTROL, 8'h00);
      rd(EIT_ADDR_COUNT, 8'h00);
      print_verdict();
   end
endmodule // tb_top
